/* File: test/axi_lite_write_channel_fifo_tb_top.sv */
// Self-checking bench of the write-channel FIFO block
module axi_lite_write_channel_fifo_tb_top
  import awfifo_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, v;
  logic              e;
  logic [ADDR_W-1:0] sAwaddr, mAwaddr;
  logic [PROT_W-1:0] sAwprot, mAwprot;
  logic              sAwvalid, sAwready, mAwvalid, mAwready;
  logic [DATA_W-1:0] sWdata, mWdata;
  logic [STRB_W-1:0] sWstrb, mWstrb;
  logic              sWvalid, sWready, mWvalid, mWready;
  logic [CNT_W-1:0]  lvlW, lvlR, lvlC;
  logic              rdRef, wrRef, hiFlag, loFlag;
  logic [1:0]        sinkMode;
  int                nMismatch, checksDone, n;

  axi_lite_write_channel_fifo i_dut (
    .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .s_axi_awaddr(sAwaddr), .s_axi_awprot(sAwprot), .s_axi_awvalid(sAwvalid),
    .s_axi_awready(sAwready), .m_axi_awaddr(mAwaddr), .m_axi_awprot(mAwprot),
    .m_axi_awvalid(mAwvalid), .m_axi_awready(mAwready), .s_axi_wdata(sWdata),
    .s_axi_wstrb(sWstrb), .s_axi_wvalid(sWvalid), .s_axi_wready(sWready),
    .m_axi_wdata(mWdata), .m_axi_wstrb(mWstrb), .m_axi_wvalid(mWvalid),
    .m_axi_wready(mWready), .addr_fifo_fill_level_wside(lvlW),
    .addr_fifo_fill_level_rside(lvlR), .addr_fifo_fill_level_common(lvlC),
    .addr_fifo_empty_read_refused(rdRef), .addr_fifo_full_write_refused(wrRef),
    .addr_fifo_high_water_flag(hiFlag), .addr_fifo_low_water_flag(loFlag));

  axi_sink_model i_sink (
    .mclk(mclk), .rst_n(rst_n), .mode(sinkMode), .m_axi_awaddr(mAwaddr),
    .m_axi_awprot(mAwprot), .m_axi_awvalid(mAwvalid), .m_axi_awready(mAwready),
    .m_axi_wdata(mWdata), .m_axi_wstrb(mWstrb), .m_axi_wvalid(mWvalid),
    .m_axi_wready(mWready));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [AW_W-1:0] awOf(input int i);
    return {ADDR_W'(32'h4000_0000 + 4 * i), PROT_W'(i)};
  endfunction

  // Strobe cycles through every byte-lane pattern
  function automatic logic [WD_W-1:0] wOf(input int i);
    return {DATA_W'(32'hC0DE_0000 + 32'h0101 * i), STRB_W'(i)};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    v = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic rdReg(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, v);
  endtask

  // Each channel releases its valid at the edge where its own ready is seen
  task automatic push(input int i);
    bit awDone, wDone;
    int k;
    awDone = 0;
    wDone  = 0;
    k      = 0;
    @(posedge mclk);
    {sAwaddr, sAwprot} <= awOf(i);
    {sWdata, sWstrb}   <= wOf(i);
    sAwvalid <= 1'b1;
    sWvalid  <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
      if (!awDone && sAwready === 1'b1) begin
        awDone = 1;
        sAwvalid <= 1'b0;
      end
      if (!wDone && sWready === 1'b1) begin
        wDone = 1;
        sWvalid <= 1'b0;
      end
    end while (!(awDone && wDone) && k < 200);
    chk("push accepted", 32'h1, 32'(awDone && wDone));
  endtask

  task automatic lvl(input int c);
    chk("count wside", 32'(c), 32'(lvlW));
    chk("count rside", 32'(c), 32'(lvlR));
    chk("count common", 32'(c), 32'(lvlC));
    chk("high flag", 32'(c >= HIGH_WATER_RST), 32'(hiFlag));
    chk("low flag", 32'(c <= LOW_WATER_RST), 32'(loFlag));
    chk("m awvalid", 32'(c != 0), 32'(mAwvalid));
    chk("s awready", 32'(c < DEPTH), 32'(sAwready));
  endtask

  task automatic drained(input int c);
    n = 0;
    while ((i_sink.awQ.size() < c || i_sink.wQ.size() < c) && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    chk("beats out", 32'(c), 32'(i_sink.awQ.size()));
    chk("data beats out", 32'(c), 32'(i_sink.wQ.size()));
  endtask

  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and tests
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = !mclk;
  end

  // Whole run needs well under two thousand cycles
  initial begin
    #50000;
    nMismatch++;
    testDone();
  end

  initial begin
    {rst_n, psel, penable, pwrite, sAwvalid, sWvalid} = '0;
    {paddr, pwdata, sAwaddr, sAwprot, sWdata, sWstrb, sinkMode} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // Readiness rises only after the first edge out of reset
    chk("awready at release", 32'h0, 32'(sAwready));
    @(posedge mclk);
    lvl(0);
    // Thresholds still hold their reset values; nothing has written them yet
    rdReg("high level", OFS_HIGH_WATER, 32'(HIGH_WATER_RST));
    rdReg("low level", OFS_LOW_WATER, 32'(LOW_WATER_RST));
    rdReg("level reg", OFS_LEVEL, 32'h1 << LVL_LOW);
    rdReg("int enable", OFS_INT_ENABLE, 32'(INT_ENABLE_RST));
    rdReg("int clear", OFS_INT_CLEAR, 32'h0);
    rdReg("unmapped", 8'h18, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    apb(1'b1, OFS_INT_ENABLE, 32'h1 << EV_HIGH_RISE);
    // Fill with the far side stalled
    for (int i = 0; i < DEPTH; i++) begin
      push(i);
      @(posedge mclk);
      lvl(i + 1);
    end
    rdReg("level full", OFS_LEVEL, 32'h0001_1010);
    rdReg("status full", OFS_INT_STATUS, 32'h1 << EV_HIGH_RISE);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b1, OFS_INT_CLEAR, 32'hF);
    rdReg("status clr", OFS_INT_STATUS, 32'h0);
    chk("irq cleared", 32'h0, 32'(irq));
    // Beat offered while full must wait, then drain slowly
    fork
      push(DEPTH);
      begin
        repeat (3) @(posedge mclk);
        chk("awready full", 32'h0, 32'(sAwready));
        chk("wready full", 32'h0, 32'(sWready));
        chk("overflow", 32'h0, 32'(wrRef));
        chk("underflow", 32'h0, 32'(rdRef));
        chk("held count", 32'(DEPTH), 32'(lvlC));
        sinkMode <= 2'd2;
      end
    join
    drained(DEPTH + 1);
    // Beats one idle cycle apart through a prompt far side
    sinkMode <= 2'd1;
    for (int i = DEPTH + 1; i < DEPTH + 4; i++) begin
      push(i);
    end
    drained(DEPTH + 4);
    for (int i = 0; i < DEPTH + 4; i++) begin
      chk("aw beat", 32'(awOf(i)), 32'(i_sink.awQ[i]));
      chk("aw addr top", 32'(awOf(i) >> 32), 32'(i_sink.awQ[i] >> 32));
      chk("w data", 32'(wOf(i) >> STRB_W), 32'(i_sink.wQ[i] >> STRB_W));
      chk("w strobe", 32'(wOf(i) & 4'hF), 32'(i_sink.wQ[i] & 4'hF));
    end
    repeat (2) @(posedge mclk);
    lvl(0);
    chk("m wvalid", 32'h0, 32'(mWvalid));
    rdReg("status low", OFS_INT_STATUS, 32'h1 << EV_LOW_RISE);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, OFS_INT_ENABLE, 32'h1 << EV_LOW_RISE);
    repeat (2) @(posedge mclk);
    chk("irq enabled", 32'h1, 32'(irq));
    apb(1'b1, OFS_INT_CLEAR, 32'h1 << EV_LOW_RISE);
    repeat (2) @(posedge mclk);
    chk("irq off", 32'h0, 32'(irq));
    testDone();
  end
endmodule

/* File: test/axi_sink_model.sv */
// Downstream write-channel slave model with prompt, slow and stalled readiness
module axi_sink_model
  import awfifo_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Readiness: 0 stalled, 1 prompt, 2 slow
  input  wire logic [1:0]        mode,
  // Write-address channel
  input  wire logic [ADDR_W-1:0] m_axi_awaddr,
  input  wire logic [PROT_W-1:0] m_axi_awprot,
  input  wire logic              m_axi_awvalid,
  output logic                   m_axi_awready,
  // Write-data channel
  input  wire logic [DATA_W-1:0] m_axi_wdata,
  input  wire logic [STRB_W-1:0] m_axi_wstrb,
  input  wire logic              m_axi_wvalid,
  output logic                   m_axi_wready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [AW_W-1:0] awQ[$];
  logic [WD_W-1:0] wQ[$];
  logic            phase_r;

  // Slow mode gives the two channels opposite phases so their levels drift apart
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      m_axi_awready <= 1'b0;
      m_axi_wready  <= 1'b0;
      phase_r       <= 1'b0;
    end else begin
      phase_r       <= !phase_r;
      m_axi_awready <= (mode == 2'd1) || ((mode == 2'd2) && phase_r);
      m_axi_wready  <= (mode == 2'd1) || ((mode == 2'd2) && !phase_r);
      if (m_axi_awvalid && m_axi_awready) begin
        awQ.push_back({m_axi_awaddr, m_axi_awprot});
      end
      if (m_axi_wvalid && m_axi_wready) begin
        wQ.push_back({m_axi_wdata, m_axi_wstrb});
      end
    end
  end
endmodule

/* File: verilog/awfifo_pkg.sv */
// Shared constants of the write-channel FIFO block
package awfifo_pkg;
  localparam int DEPTH  = 16;
  localparam int ADDR_W = 32;
  localparam int PROT_W = 3;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int PTR_W  = $clog2(DEPTH);
  localparam int CNT_W  = $clog2(DEPTH) + 1;
  localparam int THR_W  = $clog2(DEPTH) - 1 + 1;
  localparam int AW_W   = ADDR_W + PROT_W;
  localparam int WD_W   = STRB_W + DATA_W;

  // APB byte offsets
  localparam logic [7:0] OFS_HIGH_WATER = 8'h00;
  localparam logic [7:0] OFS_LOW_WATER  = 8'h04;
  localparam logic [7:0] OFS_LEVEL      = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INT_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h14;

  // Level register field positions
  localparam int LVL_AW_CNT = 0;
  localparam int LVL_W_CNT  = 8;
  localparam int LVL_HIGH   = 16;
  localparam int LVL_LOW    = 17;

  // Interrupt event bits
  localparam int EV_OVERFLOW  = 0;
  localparam int EV_UNDERFLOW = 1;
  localparam int EV_HIGH_RISE = 2;
  localparam int EV_LOW_RISE  = 3;
  localparam int EV_W         = 4;

  // Values after reset
  localparam logic [THR_W-1:0] HIGH_WATER_RST = 4'hE;
  localparam logic [THR_W-1:0] LOW_WATER_RST  = 4'h2;
  localparam logic [EV_W-1:0]  INT_ENABLE_RST = 4'h0;
endpackage

/* File: verilog/axi_lite_write_channel_fifo.sv */
// Write-address and write-data channel FIFOs with APB status registers
//
// Functional notes
// - Write-side count never shows fewer words than held.
// - A write shows in the write-side count at the next edge.
// - Read-side count never shows more readable words than held.
// - A read shows in the read-side count at the next edge.
// - Common count gives words stored, same width as other counts.
// - Underflow flags a refused read one cycle later, contents untouched.
// - Underflow may stay zero since empty reads are blocked.
// - High-water flag high while count at or above threshold.
// - Low-water flag high while count at or below threshold.
// - Data width is one of 8 to 512 in powers of two.
// - One strobe bit per data byte, bit n covers byte n.
// - Strobe bit 0 is the lowest byte; one marks byte valid.
// - Data and strobes stored together and presented together.
// - Slave-face ready high only when a beat can be stored.
// - Master-face valid high while a beat is held.
// - Overflow flags a refused write, may stay zero.
module axi_lite_write_channel_fifo
  import awfifo_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // Write-address slave face
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [PROT_W-1:0] s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // Write-address master face
  output logic [ADDR_W-1:0]      m_axi_awaddr,
  output logic [PROT_W-1:0]      m_axi_awprot,
  output logic                   m_axi_awvalid,
  input  wire logic              m_axi_awready,
  // Write-data slave face
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [STRB_W-1:0] s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // Write-data master face
  output logic [DATA_W-1:0]      m_axi_wdata,
  output logic [STRB_W-1:0]      m_axi_wstrb,
  output logic                   m_axi_wvalid,
  input  wire logic              m_axi_wready,
  // Address FIFO sidebands
  output logic [CNT_W-1:0]       addr_fifo_fill_level_wside,
  output logic [CNT_W-1:0]       addr_fifo_fill_level_rside,
  output logic [CNT_W-1:0]       addr_fifo_fill_level_common,
  output logic                   addr_fifo_empty_read_refused,
  output logic                   addr_fifo_full_write_refused,
  output logic                   addr_fifo_high_water_flag,
  output logic                   addr_fifo_low_water_flag
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  fifo_stat_if #(.CW(CNT_W)) awStat ();
  fifo_stat_if #(.CW(CNT_W)) wStat ();

  logic [AW_W-1:0]  awOut;
  logic [WD_W-1:0]  wOut;
  logic [THR_W-1:0] highLevel_r;
  logic [THR_W-1:0] lowLevel_r;
  logic [EV_W-1:0]  intStatus_r;
  logic [EV_W-1:0]  intStatus_nxt;
  logic [EV_W-1:0]  intEnable_r;
  logic [EV_W-1:0]  events;
  logic [EV_W-1:0]  clearMask;
  logic             highFlag_r;
  logic             lowFlag_r;
  logic             highFlag_nxt;
  logic             lowFlag_nxt;
  logic             irq_r;
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [31:0]      levelWord;
  logic [31:0]      readMux;

  // ****************************************************************
  // Channel FIFOs
  // ****************************************************************
  // Upstream valid is the write request; readiness is the FIFO's
  chan_fifo #(.W(AW_W)) u_aw_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inData   ({s_axi_awprot, s_axi_awaddr}),
    .inValid  (s_axi_awvalid),
    .inReady  (s_axi_awready),
    .outData  (awOut),
    .outValid (m_axi_awvalid),
    .outReady (m_axi_awready),
    .stat     (awStat.source)
  );

  // Strobes ride beside the data in one stored word
  chan_fifo #(.W(WD_W)) u_w_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inData   ({s_axi_wstrb, s_axi_wdata}),
    .inValid  (s_axi_wvalid),
    .inReady  (s_axi_wready),
    .outData  (wOut),
    .outValid (m_axi_wvalid),
    .outReady (m_axi_wready),
    .stat     (wStat.source)
  );

  assign m_axi_awaddr = awOut[ADDR_W-1:0];
  assign m_axi_awprot = awOut[AW_W-1:ADDR_W];
  // Strobe bit n lines up with data byte n, bit 0 the lowest
  assign m_axi_wdata  = wOut[DATA_W-1:0];
  assign m_axi_wstrb  = wOut[WD_W-1:DATA_W];

  // ****************************************************************
  // Fill levels and water marks
  // ****************************************************************
  // One clock: exact count serves both sides, neither over nor under
  assign addr_fifo_fill_level_wside  = awStat.count;
  assign addr_fifo_fill_level_rside  = awStat.count;
  assign addr_fifo_fill_level_common = awStat.count;
  assign addr_fifo_empty_read_refused = awStat.popErr;
  assign addr_fifo_full_write_refused = awStat.pushErr;

  // Judged on next count so the flag lines up with the count
  assign highFlag_nxt = awStat.countNxt >= {1'b0, highLevel_r};
  assign lowFlag_nxt  = awStat.countNxt <= {1'b0, lowLevel_r};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      highFlag_r <= 1'b0;
      lowFlag_r  <= 1'b1;
    end else begin
      highFlag_r <= highFlag_nxt;
      lowFlag_r  <= lowFlag_nxt;
    end
  end

  assign addr_fifo_high_water_flag = highFlag_r;
  assign addr_fifo_low_water_flag  = lowFlag_r;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // One wait state so that every APB output leaves a flip-flop
  wire apbAccess = psel && penable;
  wire apbFirst  = apbAccess && !pready_r;
  wire apbDone   = apbAccess && pready_r;
  wire apbWrite  = apbDone && pwrite;
  wire selHigh   = paddr == OFS_HIGH_WATER;
  wire selLow    = paddr == OFS_LOW_WATER;
  wire selLevel  = paddr == OFS_LEVEL;
  wire selStatus = paddr == OFS_INT_STATUS;
  wire selClear  = paddr == OFS_INT_CLEAR;
  wire selEnable = paddr == OFS_INT_ENABLE;
  wire addrHit   = selHigh || selLow || selLevel ||
                   selStatus || selClear || selEnable;

  assign levelWord = (32'(awStat.count) << LVL_AW_CNT) |
                     (32'(wStat.count) << LVL_W_CNT) |
                     (32'(highFlag_r) << LVL_HIGH) |
                     (32'(lowFlag_r) << LVL_LOW);

  // Clear register is write-only and reads as zero
  assign readMux = selHigh   ? 32'(highLevel_r) :
                   selLow    ? 32'(lowLevel_r)  :
                   selLevel  ? levelWord        :
                   selStatus ? 32'(intStatus_r) :
                   selEnable ? 32'(intEnable_r) : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= apbFirst;
      pslverr_r <= apbFirst && !addrHit;
      prdata_r  <= (apbFirst && !pwrite) ? readMux : 32'h0000_0000;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Threshold writes are not blocked outside reset; software must
  // program them while the channel is idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      highLevel_r <= HIGH_WATER_RST;
      lowLevel_r  <= LOW_WATER_RST;
      intEnable_r <= INT_ENABLE_RST;
    end else begin
      if (apbWrite && selHigh) begin
        highLevel_r <= pwdata[THR_W-1:0];
      end
      if (apbWrite && selLow) begin
        lowLevel_r <= pwdata[THR_W-1:0];
      end
      if (apbWrite && selEnable) begin
        intEnable_r <= pwdata[EV_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign events[EV_OVERFLOW]  = awStat.pushErr;
  assign events[EV_UNDERFLOW] = awStat.popErr;
  assign events[EV_HIGH_RISE] = highFlag_nxt && !highFlag_r;
  assign events[EV_LOW_RISE]  = lowFlag_nxt && !lowFlag_r;
  assign clearMask = (apbWrite && selClear) ? pwdata[EV_W-1:0] : '0;
  // Event in the clearing cycle survives: set wins
  assign intStatus_nxt = (intStatus_r & ~clearMask) | events;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intStatus_r <= '0;
      irq_r       <= 1'b0;
    end else begin
      intStatus_r <= intStatus_nxt;
      irq_r       <= |(intStatus_nxt & intEnable_r);
    end
  end

  assign irq = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam bit DATA_W_OK = (DATA_W == 8) || (DATA_W == 16) ||
                             (DATA_W == 32) || (DATA_W == 64) ||
                             (DATA_W == 128) || (DATA_W == 256) ||
                             (DATA_W == 512);

  wire awPush = s_axi_awvalid && s_axi_awready;
  wire awPop  = m_axi_awvalid && m_axi_awready;
  wire wPush  = s_axi_wvalid && s_axi_wready;
  wire wPop   = m_axi_wvalid && m_axi_wready;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Ready is still low at the first edge after reset release
  property p_wside_never_low;
    $past(rst_n) |-> addr_fifo_fill_level_wside <= CNT_W'(DEPTH) &&
      (s_axi_awready == (addr_fifo_fill_level_wside != CNT_W'(DEPTH)));
  endproperty
  a_wside_never_low: assert property (p_wside_never_low)
    else $error("write-side count disagrees with ready");

  property p_wside_one_late;
    awPush && !awPop |=> addr_fifo_fill_level_wside ==
      $past(addr_fifo_fill_level_wside) + 1'b1;
  endproperty
  a_wside_one_late: assert property (p_wside_one_late)
    else $error("write not counted at the next edge");

  property p_rside_one_late;
    awPop && !awPush |=> addr_fifo_fill_level_rside ==
      $past(addr_fifo_fill_level_rside) - 1'b1;
  endproperty
  a_rside_one_late: assert property (p_rside_one_late)
    else $error("read not counted at the next edge");

  property p_common_count;
    addr_fifo_fill_level_common == addr_fifo_fill_level_wside &&
      addr_fifo_fill_level_common == addr_fifo_fill_level_rside;
  endproperty
  a_common_count: assert property (p_common_count)
    else $error("common count differs from side counts");

  property p_no_refusals;
    !addr_fifo_empty_read_refused && !addr_fifo_full_write_refused;
  endproperty
  a_no_refusals: assert property (p_no_refusals)
    else $error("refused transfer reported");

  property p_high_water;
    $stable(highLevel_r) |-> addr_fifo_high_water_flag ==
      (addr_fifo_fill_level_common >= {1'b0, highLevel_r});
  endproperty
  a_high_water: assert property (p_high_water)
    else $error("high-water flag wrong");

  property p_low_water;
    $stable(lowLevel_r) |-> addr_fifo_low_water_flag ==
      (addr_fifo_fill_level_common <= {1'b0, lowLevel_r});
  endproperty
  a_low_water: assert property (p_low_water)
    else $error("low-water flag wrong");

  property p_width_legal;
    DATA_W_OK && (STRB_W * 8 == DATA_W);
  endproperty
  a_width_legal: assert property (p_width_legal)
    else $error("illegal data width");

  property p_pass_through;
    wPush && !m_axi_wvalid |=> m_axi_wvalid &&
      m_axi_wdata == $past(s_axi_wdata) &&
      m_axi_wstrb == $past(s_axi_wstrb);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("data or strobe not carried through");

  property p_valid_when_held;
    m_axi_awvalid == (addr_fifo_fill_level_common != '0);
  endproperty
  a_valid_when_held: assert property (p_valid_when_held)
    else $error("master valid disagrees with count");

  property p_stable_until_taken;
    m_axi_awvalid && !m_axi_awready |=> m_axi_awvalid &&
      $stable(m_axi_awaddr) && $stable(m_axi_awprot);
  endproperty
  a_stable_until_taken: assert property (p_stable_until_taken)
    else $error("address beat changed before acceptance");

  property p_irq_follows;
    ##1 irq == |($past(intStatus_nxt) & $past(intEnable_r));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt output wrong");

  c_aw_full: cover property (addr_fifo_fill_level_common == CNT_W'(DEPTH));
  c_high_water: cover property (!addr_fifo_high_water_flag ##1
                                addr_fifo_high_water_flag);
  c_w_stream: cover property (wPush && wPop [*3]);
  c_irq: cover property (!irq ##1 irq);
endmodule

/* File: verilog/chan_fifo.sv */
// Single-clock channel FIFO with registered head word and fill level
module chan_fifo
  import awfifo_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Fill face
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  // Drain face
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady,
  // Status
  fifo_stat_if.source       stat
);
  logic [W-1:0]     mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W-1:0] rdPtr_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [W-1:0]     head_nxt;
  logic             inReady_r;
  logic             outValid_r;
  logic [W-1:0]     outData_r;
  logic             pushErr_r;
  logic             popErr_r;
  wire              push;
  wire              pop;

  // Transfers only on valid and ready together
  assign push      = inValid && inReady_r;
  assign pop       = outValid_r && outReady;
  assign rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
  assign count_nxt = count_r + CNT_W'(push) - CNT_W'(pop);
  // Bypass when the new word becomes the only one held
  assign head_nxt  = (count_r == CNT_W'(pop)) ? inData : mem[rdPtr_nxt];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r    <= '0;
      rdPtr_r    <= '0;
      count_r    <= '0;
      inReady_r  <= 1'b0;
      outValid_r <= 1'b0;
      outData_r  <= '0;
      pushErr_r  <= 1'b0;
      popErr_r   <= 1'b0;
    end else begin
      wrPtr_r    <= push ? wrPtr_r + 1'b1 : wrPtr_r;
      rdPtr_r    <= rdPtr_nxt;
      count_r    <= count_nxt;
      inReady_r  <= count_nxt != CNT_W'(DEPTH);
      outValid_r <= count_nxt != '0;
      outData_r  <= head_nxt;
      // Full and empty gate the handshakes, so these never fire
      pushErr_r  <= push && (count_r == CNT_W'(DEPTH));
      popErr_r   <= pop && (count_r == '0);
    end
  end

  assign inReady       = inReady_r;
  assign outValid      = outValid_r;
  assign outData       = outData_r;
  assign stat.count    = count_r;
  assign stat.countNxt = count_nxt;
  assign stat.pushErr  = pushErr_r;
  assign stat.popErr   = popErr_r;
endmodule

/* File: verilog/fifo_stat_if.sv */
// Fill-level and error status carried from a channel FIFO to its owner
interface fifo_stat_if #(parameter int CW = 5);
  logic [CW-1:0] count;
  logic [CW-1:0] countNxt;
  logic          pushErr;
  logic          popErr;
  modport source (output count, output countNxt, output pushErr, output popErr);
  modport sink   (input count, input countNxt, input pushErr, input popErr);
endinterface
